// File: hdl/gp_pkg.sv
/*
  Constants, register map and state layout of the general-purpose I/O port.
  Assumes one port of sixteen pins behind an APB slave with 32-bit data.
*/
package gp_pkg;
  // ==========================================================
  // Sizes
  localparam int GP_NPINS = 16;
  localparam int GP_NAF   = 8;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] GP_OFS_MODE  = 8'h00;
  localparam logic [7:0] GP_OFS_OTYPE = 8'h04;
  localparam logic [7:0] GP_OFS_SPEED = 8'h08;
  localparam logic [7:0] GP_OFS_PULL  = 8'h0C;
  localparam logic [7:0] GP_OFS_IDATA = 8'h10;
  localparam logic [7:0] GP_OFS_ODATA = 8'h14;
  localparam logic [7:0] GP_OFS_BSC   = 8'h18;
  localparam logic [7:0] GP_OFS_ALFL  = 8'h20;
  localparam logic [7:0] GP_OFS_ALFH  = 8'h24;

  // ==========================================================
  // Field codes
  localparam logic [1:0] GP_MODE_IN   = 2'h0;
  localparam logic [1:0] GP_MODE_OUT  = 2'h1;
  localparam logic [1:0] GP_MODE_AF   = 2'h2;
  localparam logic [1:0] GP_MODE_ANA  = 2'h3;
  localparam logic [1:0] GP_PULL_NONE = 2'h0;
  localparam logic [1:0] GP_PULL_UP   = 2'h1;
  localparam logic [1:0] GP_PULL_DN   = 2'h2;
  localparam logic       GP_OT_PP     = 1'h0;
  localparam logic       GP_OT_OD     = 1'h1;
  localparam int         GP_BSC_CLR_LSB = 16;

  // ==========================================================
  // Values after reset; port A brings up its two debug pins
  localparam logic [31:0] GP_MODE_RST_A = 32'h2800_0000;
  // Pin fourteen pull-up, pin thirteen pull-down, so the pads never flip after reset
  localparam logic [31:0] GP_PULL_RST_A = 32'h1800_0000;
  localparam logic [31:0] GP_MODE_RST   = 32'h0000_0000;
  localparam logic [31:0] GP_PULL_RST   = 32'h0000_0000;
  localparam logic [15:0] GP_PU_RST_A   = 16'h4000;
  localparam logic [15:0] GP_PD_RST_A   = 16'h2000;
  localparam logic [15:0] GP_SCHM_RST   = 16'hFFFF;

  // ==========================================================
  // Pad control bundle
  typedef struct packed {
    logic [GP_NPINS-1:0] out;
    logic [GP_NPINS-1:0] oe_n;
    logic [GP_NPINS-1:0] pu;
    logic [GP_NPINS-1:0] pd;
    logic [GP_NPINS-1:0] schm;
  } gp_pad_t;

  // All state of the port
  typedef struct packed {
    logic [31:0]                        mode_r;
    logic [GP_NPINS-1:0]                otype_r;
    logic [31:0]                        speed_r;
    logic [31:0]                        pull_r;
    logic [GP_NPINS-1:0]                idata_r;
    logic [GP_NPINS-1:0]                odata_r;
    logic [31:0]                        alfl_r;
    logic [31:0]                        alfh_r;
    logic [GP_NPINS-1:0]                s1_r;
    logic [GP_NPINS-1:0]                s2_r;
    logic [GP_NPINS-1:0]                s3_r;
    logic [GP_NPINS-1:0]                lvl_r;
    gp_pad_t                            pad_r;
    logic [GP_NAF-1:0][GP_NPINS-1:0]    af_in_r;
    logic [31:0]                        prdata_r;
    logic                               pready_r;
    logic                               pslverr_r;
  } gp_state_t;
endpackage : gp_pkg

// File: hdl/gp_port.sv
/*
  GPIO port: per-pin mode, pull, output type and function multiplexer, input
  sampling and atomic set/clear of the output data, reached over APB.
  Assumes pads resolve pin level from out/oe_n/pu/pd and that peripherals
  present one output value per pin and function on af_out.
*/
// How it works
// - Reset leaves non-alternate pins as floating inputs.
// - Port A pin fourteen resets alternate with pull-up, pin thirteen with pull-down.
// - Input mode turns on Schmitt input, off driver, applies chosen pulls.
// - Input data register samples pin levels every clock while Schmitt is on.
// - Undriven input reads high with pull-up and low with pull-down.
// - Output mode enables driver and Schmitt, honours speed, type and pulls.
// - Push-pull drives the output data bit; output data reads back as written.
// - Open-drain only pulls low or floats; real level readable as input data.
// - Alternate mode drives pin from selected peripheral, Schmitt and pulls on.
// - Analog mode disables driver, pulls and Schmitt; input data forced zero.
// - Set/clear register has set and clear bit per pin; zeros change nothing.
// - Set wins when set and clear of one pin are written together.
// - A set/clear write updates output data in one atomic step.
// - Each pin has a 4-bit function selector; functions zero to seven used.
// - Reset selects function zero on every pin.
// - Each pin joins one function and each function one pin at a time.
// - Mode field codes input 00, output 01, alternate 10, analog 11.
// - Pull field codes none 00, pull-up 01, pull-down 10.
// - Output type field: 0 push-pull, 1 open-drain.
module gp_port
  import gp_pkg::*;
#(
  parameter bit PORT_A = 1'b1
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Pads
  input  wire logic [GP_NPINS-1:0]               pad_in,
  output gp_pad_t                                pad_ctl,
  output logic      [31:0]                       pad_speed,
  // Peripheral functions
  input  wire logic [GP_NPINS-1:0][GP_NAF-1:0]   af_out,
  output logic      [GP_NAF-1:0][GP_NPINS-1:0]   af_in
);

  // ==========================================================
  // Field helpers
  function automatic logic [1:0] fld2(input logic [31:0] r, input int i);
    fld2 = r[2*i +: 2];
  endfunction : fld2

  function automatic logic [3:0] afsel(input logic [31:0] lo, input logic [31:0] hi, input int i);
    afsel = (i < 8) ? lo[4*i +: 4] : hi[4*(i-8) +: 4];
  endfunction : afsel

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == GP_OFS_MODE) || (a == GP_OFS_OTYPE) || (a == GP_OFS_SPEED) || (a == GP_OFS_PULL) ||
             (a == GP_OFS_IDATA) || (a == GP_OFS_ODATA) || (a == GP_OFS_BSC) || (a == GP_OFS_ALFL) ||
             (a == GP_OFS_ALFH);
  endfunction : mapped

  gp_state_t s;
  gp_state_t n;

  logic              wr_acc;
  logic [7:0]        ofs;
  logic [GP_NPINS-1:0] in_m, ana_m, pp_m, od_m;

  assign ofs    = paddr[7:0];
  assign wr_acc = psel && penable && s.pready_r && pwrite;

  // ==========================================================
  // Next state
  always_comb begin
    logic [1:0]        md;
    logic [1:0]        pl;
    logic [3:0]        fs;
    logic              v;
    logic              own;
    logic [GP_NAF-1:0] claim;
    md    = GP_MODE_IN;
    pl    = GP_PULL_NONE;
    fs    = 4'h0;
    v     = 1'b1;
    own   = 1'b0;
    claim = '0;
    n     = s;

    // Three-stage pin sampling; a level counts once stages two and three agree
    n.s1_r  = pad_in;
    n.s2_r  = s.s1_r;
    n.s3_r  = s.s2_r;
    n.lvl_r = (~(s.s2_r ^ s.s3_r) & s.s2_r) | ((s.s2_r ^ s.s3_r) & s.lvl_r);

    // Register writes land in the access phase only
    if (wr_acc) begin
      case (ofs)
        GP_OFS_MODE:  n.mode_r  = pwdata;
        GP_OFS_OTYPE: n.otype_r = pwdata[GP_NPINS-1:0];
        GP_OFS_SPEED: n.speed_r = pwdata;
        GP_OFS_PULL:  n.pull_r  = pwdata;
        GP_OFS_ODATA: n.odata_r = pwdata[GP_NPINS-1:0];
        // Single update of the whole word, no read-modify-write window
        GP_OFS_BSC:   n.odata_r = (s.odata_r & ~pwdata[GP_BSC_CLR_LSB +: GP_NPINS])
                                  | pwdata[GP_NPINS-1:0];
        GP_OFS_ALFL:  n.alfl_r  = pwdata;
        GP_OFS_ALFH:  n.alfh_r  = pwdata;
        default:      n.odata_r = s.odata_r;
      endcase
    end

    // Read data is fetched in setup so it leaves a flop; zero wait states
    n.pready_r  = psel && !penable;
    n.pslverr_r = psel && !penable && !mapped(ofs);
    n.prdata_r  = s.prdata_r;
    if (psel && !penable) begin
      case (ofs)
        GP_OFS_MODE:  n.prdata_r = s.mode_r;
        GP_OFS_OTYPE: n.prdata_r = {16'h0000, s.otype_r};
        GP_OFS_SPEED: n.prdata_r = s.speed_r;
        GP_OFS_PULL:  n.prdata_r = s.pull_r;
        GP_OFS_IDATA: n.prdata_r = {16'h0000, s.idata_r};
        GP_OFS_ODATA: n.prdata_r = {16'h0000, s.odata_r};
        GP_OFS_ALFL:  n.prdata_r = s.alfl_r;
        GP_OFS_ALFH:  n.prdata_r = s.alfh_r;
        default:      n.prdata_r = 32'h0000_0000;
      endcase
    end

    // Per-pin pad control and function routing
    n.af_in_r = '0;
    for (int i = 0; i < GP_NPINS; i++) begin
      md = fld2(s.mode_r, i);
      pl = fld2(s.pull_r, i);
      fs = afsel(s.alfl_r, s.alfh_r, i);
      // Lowest pin claiming a function gets it; later claimants idle high
      own = (md == GP_MODE_AF) && !fs[3] && !claim[fs[2:0]];
      if (own) begin
        claim[fs[2:0]]           = 1'b1;
        n.af_in_r[fs[2:0]][i]    = s.lvl_r[i];
      end
      v = (md == GP_MODE_AF) ? (own ? af_out[i][fs[2:0]] : 1'b1) : s.odata_r[i];
      n.pad_r.pu[i]   = (pl == GP_PULL_UP) && (md != GP_MODE_ANA);
      n.pad_r.pd[i]   = (pl == GP_PULL_DN) && (md != GP_MODE_ANA);
      n.pad_r.schm[i] = (md != GP_MODE_ANA);
      case (md)
        GP_MODE_IN: begin
          n.pad_r.out[i]  = 1'b0;
          n.pad_r.oe_n[i] = 1'b1;
        end
        GP_MODE_OUT, GP_MODE_AF: begin
          if (s.otype_r[i] == GP_OT_OD) begin
            n.pad_r.out[i]  = 1'b0;
            n.pad_r.oe_n[i] = v;
          end else begin
            n.pad_r.out[i]  = v;
            n.pad_r.oe_n[i] = 1'b0;
          end
        end
        GP_MODE_ANA: begin
          n.pad_r.out[i]  = 1'b0;
          n.pad_r.oe_n[i] = 1'b1;
        end
        default: begin
          n.pad_r.out[i]  = 1'b0;
          n.pad_r.oe_n[i] = 1'b1;
        end
      endcase
      // Analog pins read zero; all others sample the pin each cycle
      n.idata_r[i] = (md == GP_MODE_ANA) ? 1'b0 : s.lvl_r[i];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s             <= '0;
      s.mode_r      <= PORT_A ? GP_MODE_RST_A : GP_MODE_RST;
      s.pull_r      <= PORT_A ? GP_PULL_RST_A : GP_PULL_RST;
      s.pad_r.oe_n  <= '1;
      s.pad_r.pu    <= PORT_A ? GP_PU_RST_A : 16'h0000;
      s.pad_r.pd    <= PORT_A ? GP_PD_RST_A : 16'h0000;
      s.pad_r.schm  <= GP_SCHM_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs, each straight from the state flops
  assign prdata    = s.prdata_r;
  assign pready    = s.pready_r;
  assign pslverr   = s.pslverr_r;
  assign pad_ctl   = s.pad_r;
  assign pad_speed = s.speed_r;
  assign af_in     = s.af_in_r;

  // ==========================================================
  // Per-pin mode masks for the checks below
  always_comb begin
    in_m  = '0;
    ana_m = '0;
    pp_m  = '0;
    od_m  = '0;
    for (int i = 0; i < GP_NPINS; i++) begin
      in_m[i]  = fld2(s.mode_r, i) == GP_MODE_IN;
      ana_m[i] = fld2(s.mode_r, i) == GP_MODE_ANA;
      pp_m[i]  = (fld2(s.mode_r, i) == GP_MODE_OUT) && !s.otype_r[i];
      od_m[i]  = ((fld2(s.mode_r, i) == GP_MODE_OUT) || (fld2(s.mode_r, i) == GP_MODE_AF)) && s.otype_r[i];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_apb_ready_setup: assert property (psel && !penable |=> pready && (pslverr == !mapped($past(ofs))))
    else $error("pready not raised after setup");
  a_bsc_set_wins: assert property (wr_acc && ofs == GP_OFS_BSC |=>
    s.odata_r == (($past(s.odata_r) & ~$past(pwdata[31:16])) | $past(pwdata[15:0])))
    else $error("set/clear result wrong");
  a_odata_hold: assert property (!wr_acc |=> s.odata_r == $past(s.odata_r))
    else $error("output data changed without write");
  a_analog_quiet: assert property (##1 ((s.pad_r.schm | s.pad_r.pu | s.pad_r.pd | ~s.pad_r.oe_n)
    & $past(ana_m)) == 16'h0000)
    else $error("analog pin not quiet");
  a_analog_idata: assert property (##1 (s.idata_r & $past(ana_m)) == 16'h0000)
    else $error("analog pin reads nonzero");
  a_input_undriven: assert property (##1 ((~s.pad_r.oe_n | ~s.pad_r.schm) & $past(in_m)) == 16'h0000)
    else $error("input pin driven");
  a_pp_driven: assert property (##1 (s.pad_r.oe_n & $past(pp_m)) == 16'h0000)
    else $error("push-pull pin not driven");
  a_pp_level: assert property (##1 ((s.pad_r.out ^ $past(s.odata_r)) & $past(pp_m)) == 16'h0000)
    else $error("push-pull pin level differs from output data");
  a_od_no_high: assert property (##1 (s.pad_r.out & $past(od_m)) == 16'h0000)
    else $error("open-drain pin driven high");
  a_idata_sample: assert property (##2 (s.idata_r & ~$past(ana_m)) == ($past(s.lvl_r) & ~$past(ana_m)))
    else $error("input data not sampled");
  a_reset_af0: assert property ($fell(rst) |-> s.alfl_r == 32'h0000_0000 && s.alfh_r == 32'h0000_0000)
    else $error("function select not zero after reset");

endmodule : gp_port

// File: tb/gp_pad_model.sv
/*
  Pad model: resolves each pin level from the port's pad controls and an outside driver.
  Assumes pad_ctl as declared in gp_pkg and one clock shared with the port.
*/
module gp_pad_model
  import gp_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Port side and outside world
  input  wire gp_pad_t             pad_ctl,
  input  wire logic [GP_NPINS-1:0] ext_val,
  input  wire logic [GP_NPINS-1:0] ext_en,
  output logic      [GP_NPINS-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [GP_NPINS-1:0] wobble_r = '0;

  // =========================================================
  // Floating pins wander each cycle, so no read passes by luck
  always_ff @(posedge clk) begin
    wobble_r <= ~wobble_r;
  end

  // Port driver wins, then outside drive, then weak pulls
  always_comb begin
    for (int i = 0; i < GP_NPINS; i++) begin
      if (!pad_ctl.oe_n[i]) pin[i] = pad_ctl.out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (pad_ctl.pu[i]) pin[i] = 1'b1;
      else if (pad_ctl.pd[i]) pin[i] = 1'b0;
      else pin[i] = wobble_r[i];
    end
  end
endmodule : gp_pad_model

// File: tb/gp_port_bench.sv
/*
  Self-checking bench for the GPIO port: APB master tasks, one task per scenario.
  Assumes gp_port with PORT_A set and the pad model on its pad side.
*/
module gp_port_bench;
  import gp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = '0, pwdata = '0, prdata, pad_speed, rd;
  logic [GP_NPINS-1:0] pad_in, ext_val = '0, ext_en = '0;
  logic [GP_NPINS-1:0][GP_NAF-1:0] af_out = '0;
  logic [GP_NAF-1:0][GP_NPINS-1:0] af_in;
  gp_pad_t pad_ctl;
  logic err;
  int n_mismatch = 0, total_checks = 0;

  gp_port #(.PORT_A(1'b1)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_ctl(pad_ctl), .pad_speed(pad_speed), .af_out(af_out), .af_in(af_in));
  gp_pad_model pads (.clk(clk), .pad_ctl(pad_ctl), .ext_val(ext_val), .ext_en(ext_en), .pin(pad_in));

  // =========================================================
  // Helpers
  always #12.5 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until pready is sampled high at a rising edge; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {24'h00_0000, a};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Outputs read right after the edge still hold the value that stood before it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // =========================================================
  // Scenarios
  task automatic t_reset;
    apb(1'b0, GP_OFS_MODE, '0); chk(rd, GP_MODE_RST_A);
    apb(1'b0, GP_OFS_PULL, '0); chk(rd, GP_PULL_RST_A);
    apb(1'b0, GP_OFS_ALFL, '0); chk(rd, 32'h0000_0000);
    apb(1'b0, GP_OFS_ALFH, '0); chk(rd, 32'h0000_0000);
    chk({pad_ctl.pu, pad_ctl.pd}, {GP_PU_RST_A, GP_PD_RST_A});
    chk(pad_ctl.oe_n & 16'h9FFF, 32'h0000_9FFF);
  endtask : t_reset

  task automatic t_input;
    apb(1'b1, GP_OFS_PULL, 32'h2400_0409);
    tick(8);
    apb(1'b0, GP_OFS_IDATA, '0); chk(rd[1:0], 32'h1);
    chk({pad_ctl.oe_n[1:0], pad_ctl.schm[1:0]}, 32'hF);
    @(posedge clk);
    ext_en <= 16'h0003;
    ext_val <= 16'h0002;
    tick(8);
    apb(1'b0, GP_OFS_IDATA, '0); chk(rd[1:0], 32'h2);
    @(posedge clk);
    ext_en <= '0;
  endtask : t_input

  // Push-pull drive and set/clear with both bits of pin 1 raised
  task automatic t_output;
    apb(1'b1, GP_OFS_MODE, 32'h2800_0055);
    apb(1'b1, GP_OFS_ODATA, 32'h0000_0005);
    apb(1'b1, GP_OFS_SPEED, 32'h0000_00C4);
    apb(1'b0, GP_OFS_ODATA, '0); chk(rd, 32'h5);
    tick(2);
    chk({pad_ctl.out[3:0], pad_ctl.oe_n[3:0], pad_ctl.schm[3:0]}, 32'h50F);
    chk(pad_speed, 32'h0000_00C4);
    apb(1'b1, GP_OFS_BSC, 32'h0006_000A);
    apb(1'b0, GP_OFS_ODATA, '0); chk(rd, 32'hB);
    apb(1'b0, GP_OFS_BSC, '0); chk(rd, 32'h0);
    tick(2);
    chk(pad_ctl.out[3:0], 32'hB);
  endtask : t_output

  // Open drain on pin 0 with pull-up: high floats, low drives
  task automatic t_opendrain;
    apb(1'b1, GP_OFS_OTYPE, {16'h0000, 15'h0000, GP_OT_OD});
    tick(8);
    chk(pad_ctl.oe_n[0], 32'h1);
    apb(1'b0, GP_OFS_IDATA, '0); chk(rd[0], 32'h1);
    apb(1'b1, GP_OFS_BSC, 32'h0001_0000);
    tick(8);
    chk(pad_ctl.oe_n[0], 32'h0);
    apb(1'b0, GP_OFS_IDATA, '0); chk(rd[0], 32'h0);
  endtask : t_opendrain

  // Pin 4 on function three, pin 5 analog
  task automatic t_alt_analog;
    apb(1'b1, GP_OFS_ALFL, 32'h0003_0000);
    apb(1'b1, GP_OFS_MODE, 32'h2800_0E55);
    @(posedge clk);
    af_out[4][3] <= 1'b1;
    ext_en <= 16'h0020;
    ext_val <= 16'h0020;
    tick(8);
    chk({pad_ctl.out[4], pad_ctl.oe_n[4], pad_ctl.schm[4]}, 32'h5);
    chk(af_in[3], 32'h0010);
    chk(af_in[0], 32'h0000);
    chk({pad_ctl.oe_n[5], pad_ctl.schm[5], pad_ctl.pu[5], pad_ctl.pd[5]}, 32'h8);
    apb(1'b0, GP_OFS_IDATA, '0); chk(rd[5:4], 32'h1);
    apb(1'b0, 8'h1C, '0); chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
  endtask : t_alt_analog

  // =========================================================
  // Verdict, sequence and watchdog
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    t_reset();
    t_input();
    t_output();
    t_opendrain();
    t_alt_analog();
    conclude();
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule : gp_port_bench
